//--- logic/pll_wrap_pkg.sv
// Constants, register map and option decoding for the clock generator wrapper
package pll_wrap_pkg;

  // Target family selection
  localparam int FAM_A = 0;
  localparam int FAM_B = 1;
  localparam int FAM_UNSUP = 2;

  // Cell operation mode codes
  localparam int MODE_NORMAL = 0;
  localparam int MODE_ZDB = 1;

  // Reference period numerator
  localparam int PERIOD_NUM = 1000000000;

  // Cell vector widths
  localparam int A_OUT_W = 5;
  localparam int B_OUT_W = 6;
  localparam int ENA_W = 6;
  localparam int EXT_W = 4;

  // Variant A enable bits
  localparam logic [5:0] A_ENA_BASE = 6'h01;
  localparam logic [5:0] A_ENA_MEM = 6'h02;
  localparam logic [5:0] A_ENA_DBL = 6'h04;

  // Variant B enable values
  localparam logic [5:0] B_ENA_OFF = 6'h01;
  localparam logic [5:0] B_ENA_ON = 6'h03;
  localparam logic [3:0] B_EXT_OFF = 4'h1;
  localparam logic [3:0] B_EXT_ON = 4'h3;

  // Reference edges counted before lock
  localparam logic [4:0] LOCK_EDGES = 5'h10;

  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic CTRL_HOLD_RST = 1'b0;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_MAIN_LOCK = 0;
  localparam int STAT_BUS_LOCK = 1;
  localparam int STAT_BUS_EN = 2;
  localparam int STAT_REF_BUS = 3;
  localparam int STAT_FAM_LSB = 4;
  localparam int STAT_HOLD = 6;
  localparam int CFG_MUL_LSB = 0;
  localparam int CFG_DIV_LSB = 8;
  localparam int CFG_MEM_BIT = 16;
  localparam int CFG_DBL_BIT = 17;

  // Reference period from reference rate
  function automatic int ref_period(input int freq);
    return PERIOD_NUM / freq;
  endfunction : ref_period

  // Variant A output enables
  function automatic logic [5:0] a_enables(input int mem_opt, input int dbl_opt);
    logic [5:0] e;
    e = A_ENA_BASE;
    if (mem_opt != 0) begin
      e = e | A_ENA_MEM;
    end
    if (dbl_opt != 0) begin
      e = e | A_ENA_DBL;
    end
    return e;
  endfunction : a_enables

endpackage : pll_wrap_pkg

//--- logic/bit_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/10ps
module bit_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Level
  input wire logic i_d,
  output logic o_q
);

  logic meta_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule : bit_sync

//--- logic/pll_cell.sv
// Behavioural stand-in for the vendor PLL primitive
`timescale 1ns/10ps
module pll_cell #(
  parameter int OPER_MODE = pll_wrap_pkg::MODE_NORMAL,
  parameter int COMP_SEL = 0,
  parameter int REF_PERIOD = 10000,
  parameter int OUT_W = pll_wrap_pkg::A_OUT_W,
  parameter int CLK0_MUL = 1,
  parameter int CLK0_DIV = 1,
  parameter int CLK1_MUL = 1,
  parameter int CLK1_DIV = 1,
  parameter int CLK2_MUL = 1,
  parameter int CLK2_DIV = 1,
  parameter int EXT0_MUL = 1,
  parameter int EXT0_DIV = 1
) (
  // Reference and reset
  input wire logic i_ref_clk,
  input wire logic i_areset,
  // Enables
  input wire logic [pll_wrap_pkg::ENA_W-1:0] i_ena,
  input wire logic [pll_wrap_pkg::EXT_W-1:0] i_ext_ena,
  // Outputs
  output logic [OUT_W-1:0] o_clk,
  output logic [pll_wrap_pkg::EXT_W-1:0] o_ext_clk,
  output logic o_locked
);

  logic rst_meta_q;
  logic rst_q;
  logic [4:0] cnt_q;

  // Reset release aligned to the reference
  always_ff @(posedge i_ref_clk or posedge i_areset) begin
    if (i_areset) begin
      rst_meta_q <= 1'b1;
      rst_q <= 1'b1;
    end else begin
      rst_meta_q <= 1'b0;
      rst_q <= rst_meta_q;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_areset) begin
    if (i_areset) begin
      cnt_q <= 5'h00;
      o_locked <= 1'b0;
    end else if (rst_q) begin
      cnt_q <= 5'h00;
      o_locked <= 1'b0;
    end else begin
      if (cnt_q != pll_wrap_pkg::LOCK_EDGES) begin
        cnt_q <= cnt_q + 5'h01;
      end
      o_locked <= (cnt_q == pll_wrap_pkg::LOCK_EDGES);
    end
  end

  // Ratios are carried as parameters; the model forwards the reference
  for (genvar k = 0; k < OUT_W; k++) begin : g_out
    assign o_clk[k] = i_ena[k] & i_ref_clk;
  end
  for (genvar k = 0; k < pll_wrap_pkg::EXT_W; k++) begin : g_ext
    assign o_ext_clk[k] = i_ext_ena[k] & i_ref_clk;
  end

endmodule : pll_cell

//--- logic/pll_clock_generator_wrapper.sv
// Clock generator wrapper around one PLL cell, with a status register port
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - One PLL cell; quad and ungated outputs absent
// - A: memory option picks zero-delay, output 1
// - A: period from rate; five outputs
// - A: outputs 0,1 mul/div; output 2 doubled
// - A: enables from memory and double options
// - A: main 0, double 2, memory 1, lock
// - Inverted main is output 0 inverted
// - Reference from bus only when both options set
// - Bus clock passes through or stays zero
// - Bus lock flag always one
// - B: memory option picks zero-delay mode
// - B: enables from double-rate option
// - B: main 0, double 1, memory external 0
// - Unset cell attributes keep defaults
module pll_clock_generator_wrapper #(
  parameter int FAMILY = pll_wrap_pkg::FAM_A,
  parameter int CLK_MUL = 2,
  parameter int CLK_DIV = 1,
  parameter int REF_FREQ = 50000,
  parameter int MEM_CLK_OPTION = 0,
  parameter int DOUBLE_RATE_OPTION = 0,
  parameter int BUS_CLOCK_OPTION = 0,
  parameter int SYS_FROM_BUS = 0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Reference clocks
  input wire logic i_main_reference_input,
  input wire logic i_bus_reference_input,
  // Register port
  input wire logic [pll_wrap_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pll_wrap_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pll_wrap_pkg::DATA_W-1:0] o_rdata,
  // Generated clocks
  output logic o_main_clk,
  output logic o_inverted_main_output,
  output logic o_double_rate_output,
  output logic o_mem_clk,
  output logic o_bus_clock_passthrough,
  // Lock flags
  output logic o_main_lock_flag,
  output logic o_bus_lock_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Build-time decoding

  localparam bit REF_FROM_BUS = (BUS_CLOCK_OPTION != 0) && (SYS_FROM_BUS == 1);
  localparam bit BUS_EN = (BUS_CLOCK_OPTION != 0);
  localparam int PERIOD = pll_wrap_pkg::ref_period(REF_FREQ);
  localparam int MODE = (MEM_CLK_OPTION == 1) ? pll_wrap_pkg::MODE_ZDB :
    pll_wrap_pkg::MODE_NORMAL;
  localparam logic [1:0] FAM_CODE = 2'(FAMILY);

  logic ref_clk;
  logic cell_lock;
  logic lock_s;
  logic main_lock_q;
  logic ctrl_hold_q;
  logic cell_rst;
  logic [pll_wrap_pkg::ENA_W-1:0] cell_ena;
  logic [pll_wrap_pkg::EXT_W-1:0] cell_ext_ena;
  logic main_c;
  logic dbl_c;
  logic mem_c;
  logic [pll_wrap_pkg::DATA_W-1:0] rdata_q;

  // All checks, generate blocks too, run on the core clock
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Reference selection and bus clock

  if (REF_FROM_BUS) begin : g_ref_bus
    assign ref_clk = i_bus_reference_input;
  end else begin : g_ref_main
    assign ref_clk = i_main_reference_input;
  end

  if (BUS_EN) begin : g_bus_on
    assign o_bus_clock_passthrough = i_bus_reference_input;
  end else begin : g_bus_off
    assign o_bus_clock_passthrough = 1'b0;
  end

  assign cell_rst = i_rst | ctrl_hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // PLL cell, one per variant

  if (FAMILY == pll_wrap_pkg::FAM_A) begin : g_var_a
    logic [pll_wrap_pkg::A_OUT_W-1:0] out_a;

    assign cell_ena = pll_wrap_pkg::a_enables(MEM_CLK_OPTION, DOUBLE_RATE_OPTION);
    assign cell_ext_ena = 4'h0;

    // Attributes not listed keep the cell defaults
    pll_cell #(
      .OPER_MODE(MODE),
      .COMP_SEL((MEM_CLK_OPTION == 1) ? 1 : 0),
      .REF_PERIOD(PERIOD),
      .OUT_W(pll_wrap_pkg::A_OUT_W),
      .CLK0_MUL(CLK_MUL),
      .CLK0_DIV(CLK_DIV),
      .CLK1_MUL(CLK_MUL),
      .CLK1_DIV(CLK_DIV),
      .CLK2_MUL(CLK_MUL * 2),
      .CLK2_DIV(CLK_DIV)
    ) u_pll (
      .i_ref_clk(ref_clk),
      .i_areset(cell_rst),
      .i_ena(cell_ena),
      .i_ext_ena(cell_ext_ena),
      .o_clk(out_a),
      .o_ext_clk(),
      .o_locked(cell_lock)
    );

    assign main_c = out_a[0];
    assign dbl_c = out_a[2];
    assign mem_c = out_a[1];

    ena_a_chk_a: assert property (
      cell_ena == ((MEM_CLK_OPTION != 0 ? 6'h03 : 6'h01) |
                   (DOUBLE_RATE_OPTION != 0 ? 6'h04 : 6'h00)))
      else $error("variant A enables wrong");
    map_a_chk_a: assert property (
      o_double_rate_output == out_a[2] && o_mem_clk == out_a[1])
      else $error("variant A output map wrong");
  end else if (FAMILY == pll_wrap_pkg::FAM_B) begin : g_var_b
    logic [pll_wrap_pkg::B_OUT_W-1:0] out_b;
    logic [pll_wrap_pkg::EXT_W-1:0] ext_b;

    assign cell_ena = (DOUBLE_RATE_OPTION != 0) ? pll_wrap_pkg::B_ENA_ON :
      pll_wrap_pkg::B_ENA_OFF;
    assign cell_ext_ena = (DOUBLE_RATE_OPTION != 0) ? pll_wrap_pkg::B_EXT_ON :
      pll_wrap_pkg::B_EXT_OFF;

    // Compensation select and output 2 keep the cell defaults
    pll_cell #(
      .OPER_MODE(MODE),
      .REF_PERIOD(PERIOD),
      .OUT_W(pll_wrap_pkg::B_OUT_W),
      .CLK0_MUL(CLK_MUL),
      .CLK0_DIV(CLK_DIV),
      .CLK1_MUL(CLK_MUL * 2),
      .CLK1_DIV(CLK_DIV),
      .EXT0_MUL(CLK_MUL),
      .EXT0_DIV(CLK_DIV)
    ) u_pll (
      .i_ref_clk(ref_clk),
      .i_areset(cell_rst),
      .i_ena(cell_ena),
      .i_ext_ena(cell_ext_ena),
      .o_clk(out_b),
      .o_ext_clk(ext_b),
      .o_locked(cell_lock)
    );

    assign main_c = out_b[0];
    assign dbl_c = out_b[1];
    assign mem_c = ext_b[0];

    ena_b_chk_a: assert property (
      (DOUBLE_RATE_OPTION != 0) ? (cell_ena == 6'h03 && cell_ext_ena == 4'h3) :
      (cell_ena == 6'h01 && cell_ext_ena == 4'h1))
      else $error("variant B enables wrong");
    map_b_chk_a: assert property (
      o_double_rate_output == out_b[1] && o_mem_clk == ext_b[0])
      else $error("variant B output map wrong");
  end else begin : g_bad_family
    $error("clock generator family not supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs

  assign o_main_clk = main_c;
  assign o_inverted_main_output = ~main_c;
  assign o_double_rate_output = dbl_c;
  assign o_mem_clk = mem_c;

  ////////////////////////////////////////////////////////////////////////////
  // Lock flags

  bit_sync u_lock_sync (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_d(cell_lock),
    .o_q(lock_s)
  );

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      main_lock_q <= 1'b0;
    end else begin
      main_lock_q <= lock_s;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_lock_flag <= 1'b1;
    end else begin
      o_bus_lock_flag <= 1'b1;
    end
  end

  assign o_main_lock_flag = main_lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  // Hold bit keeps the cell in reset for relock
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_hold_q <= pll_wrap_pkg::CTRL_HOLD_RST;
    end else if (i_wr && i_addr == pll_wrap_pkg::REG_CTRL) begin
      ctrl_hold_q <= i_wdata[pll_wrap_pkg::CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (i_rd) begin
        unique case (i_addr)
          pll_wrap_pkg::REG_CTRL: begin
            rdata_q[pll_wrap_pkg::CTRL_HOLD_BIT] <= ctrl_hold_q;
          end
          pll_wrap_pkg::REG_STATUS: begin
            rdata_q[pll_wrap_pkg::STAT_MAIN_LOCK] <= main_lock_q;
            rdata_q[pll_wrap_pkg::STAT_BUS_LOCK] <= o_bus_lock_flag;
            rdata_q[pll_wrap_pkg::STAT_BUS_EN] <= BUS_EN;
            rdata_q[pll_wrap_pkg::STAT_REF_BUS] <= REF_FROM_BUS;
            rdata_q[pll_wrap_pkg::STAT_FAM_LSB +: 2] <= FAM_CODE;
            rdata_q[pll_wrap_pkg::STAT_HOLD] <= ctrl_hold_q;
          end
          pll_wrap_pkg::REG_CONFIG: begin
            rdata_q[pll_wrap_pkg::CFG_MUL_LSB +: 8] <= 8'(CLK_MUL);
            rdata_q[pll_wrap_pkg::CFG_DIV_LSB +: 8] <= 8'(CLK_DIV);
            rdata_q[pll_wrap_pkg::CFG_MEM_BIT] <= (MEM_CLK_OPTION != 0);
            rdata_q[pll_wrap_pkg::CFG_DBL_BIT] <= (DOUBLE_RATE_OPTION != 0);
          end
          default: begin
            rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign o_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  inv_clk_a: assert property (
    o_inverted_main_output == !o_main_clk)
    else $error("inverted main clock not inverse of main");

  ref_sel_a: assert property (
    REF_FROM_BUS ? (ref_clk == i_bus_reference_input) :
    (ref_clk == i_main_reference_input))
    else $error("reference selected from wrong input");

  bus_pass_a: assert property (
    o_bus_clock_passthrough == (BUS_EN ? i_bus_reference_input : 1'b0))
    else $error("bus clock passthrough wrong");

  bus_lock_a: assert property (
    o_bus_lock_flag && $stable(o_bus_lock_flag))
    else $error("bus lock flag not held high");

  main_lock_a: assert property (
    ##3 (o_main_lock_flag == $past(cell_lock, 3)))
    else $error("main lock flag does not follow cell lock");

  read_status_a: assert property (
    i_rd && i_addr == pll_wrap_pkg::REG_STATUS |=>
      o_rdata[0] == $past(o_main_lock_flag) && o_rdata[1])
    else $error("status read does not show lock flags");

  read_idle_a: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without read");

  hold_write_a: assert property (
    i_wr && i_addr == pll_wrap_pkg::REG_CTRL |=>
      ctrl_hold_q == $past(i_wdata[pll_wrap_pkg::CTRL_HOLD_BIT]))
    else $error("hold bit not taken from write");

  read_ctrl_a: assert property (
    i_rd && i_addr == pll_wrap_pkg::REG_CTRL |=>
      o_rdata == {31'h0000_0000, $past(ctrl_hold_q)})
    else $error("control read does not show hold bit");

  status_cfg_a: assert property (
    i_rd && i_addr == pll_wrap_pkg::REG_STATUS |=>
      o_rdata[3:2] == {(BUS_CLOCK_OPTION != 0) && (SYS_FROM_BUS == 1),
                       BUS_CLOCK_OPTION != 0} &&
      o_rdata[5:4] == 2'(FAMILY) && o_rdata[6] == $past(ctrl_hold_q) &&
      o_rdata[31:7] == 25'h000_0000)
    else $error("status read does not show build options");

  read_config_a: assert property (
    i_rd && i_addr == pll_wrap_pkg::REG_CONFIG |=>
      o_rdata[15:0] == {8'(CLK_DIV), 8'(CLK_MUL)} &&
      o_rdata[17:16] == {DOUBLE_RATE_OPTION != 0, MEM_CLK_OPTION != 0} &&
      o_rdata[31:18] == 14'h0000)
    else $error("config read does not show build options");

  read_unmapped_a: assert property (
    i_rd && i_addr != pll_wrap_pkg::REG_CTRL && i_addr != pll_wrap_pkg::REG_STATUS &&
      i_addr != pll_wrap_pkg::REG_CONFIG |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read returns data");

  hold_lock_a: assert property (
    ctrl_hold_q |-> !cell_lock)
    else $error("cell locked while held in reset");

  hold_drop_a: assert property (
    $rose(ctrl_hold_q) |-> ##3 !o_main_lock_flag)
    else $error("main lock flag stays high under hold");

  lock_rise_c: cover property ($rose(o_main_lock_flag));
  lock_fall_c: cover property ($fell(o_main_lock_flag));
  status_rd_c: cover property (i_rd && i_addr == pll_wrap_pkg::REG_STATUS);
  hold_set_c: cover property ($rose(ctrl_hold_q));
  cfg_rd_c: cover property (i_rd && i_addr == pll_wrap_pkg::REG_CONFIG);

endmodule : pll_clock_generator_wrapper

//--- verif/ref_clock_source.sv
// Free-running reference oscillators feeding the clock generator
`timescale 1ns/10ps
module ref_clock_source #(
  parameter real MAIN_HALF = 20.0,
  parameter real MAIN_OFS = 0.5,
  parameter real BUS_HALF = 17.0,
  parameter real BUS_OFS = 0.25
) (
  // Reference clocks
  output logic o_main_ref,
  output logic o_bus_ref
);
  // Board oscillators run free; offset keeps edges apart
  initial begin
    o_main_ref = 1'b0;
    #(MAIN_OFS);
    forever #(MAIN_HALF) o_main_ref = ~o_main_ref;
  end
  initial begin
    o_bus_ref = 1'b0;
    #(BUS_OFS);
    forever #(BUS_HALF) o_bus_ref = ~o_bus_ref;
  end
endmodule : ref_clock_source

//--- verif/test_pll_clock_generator_wrapper.sv
// Self-checking bench for the clock generator wrapper, two variants side by side
`timescale 1ns/10ps
module test_pll_clock_generator_wrapper;
  localparam int A_MUL = 4;
  localparam int A_DIV = 1;
  localparam int B_MUL = 3;
  localparam int B_DIV = 2;
  localparam int OPT_ON = 1;
  localparam int OPT_OFF = 0;
  logic i_core_clk, i_rst, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, rdata_a, rdata_b;
  logic main_ref, bus_ref;
  logic a_main, a_inv, a_dbl, a_mem, a_pass, a_lock, a_blk;
  logic b_main, b_inv, b_dbl, b_mem, b_pass, b_lock, b_blk;
  logic [63:0] exp_q[$];
  logic [63:0] mon_e;
  logic rd_d = 1'b0;
  int failures = 0;
  int num_checks = 0;

  ref_clock_source osc_u (.o_main_ref(main_ref), .o_bus_ref(bus_ref));

  pll_clock_generator_wrapper #(.FAMILY(pll_wrap_pkg::FAM_A), .CLK_MUL(A_MUL),
    .CLK_DIV(A_DIV), .MEM_CLK_OPTION(OPT_ON), .DOUBLE_RATE_OPTION(OPT_ON),
    .BUS_CLOCK_OPTION(OPT_ON), .SYS_FROM_BUS(OPT_ON)) dut_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_main_reference_input(main_ref),
    .i_bus_reference_input(bus_ref), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_a), .o_main_clk(a_main),
    .o_inverted_main_output(a_inv), .o_double_rate_output(a_dbl), .o_mem_clk(a_mem),
    .o_bus_clock_passthrough(a_pass), .o_main_lock_flag(a_lock), .o_bus_lock_flag(a_blk));

  pll_clock_generator_wrapper #(.FAMILY(pll_wrap_pkg::FAM_B), .CLK_MUL(B_MUL),
    .CLK_DIV(B_DIV), .MEM_CLK_OPTION(OPT_OFF), .DOUBLE_RATE_OPTION(OPT_OFF),
    .BUS_CLOCK_OPTION(OPT_OFF), .SYS_FROM_BUS(OPT_ON)) dut_b (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_main_reference_input(main_ref),
    .i_bus_reference_input(bus_ref), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_b), .o_main_clk(b_main),
    .o_inverted_main_output(b_inv), .o_double_rate_output(b_dbl), .o_mem_clk(b_mem),
    .o_bus_clock_passthrough(b_pass), .o_main_lock_flag(b_lock), .o_bus_lock_flag(b_blk));

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Status word: hold, family, reference from bus, bus option, bus lock, lock
  function automatic logic [63:0] stat(input logic lock, input logic hold);
    return {25'h0, hold, 2'b01, 1'b0, 1'b0, 1'b1, lock,
            25'h0, hold, 2'b00, 1'b1, 1'b1, 1'b1, lock};
  endfunction : stat

  function automatic logic [63:0] cfg();
    return {14'h0, 1'b0, 1'b0, 8'(B_DIV), 8'(B_MUL), 14'h0, 1'b1, 1'b1, 8'(A_DIV), 8'(A_MUL)};
  endfunction : cfg

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [63:0] e);
    exp_q.push_back(e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask : rd

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    @(negedge i_core_clk);
    while ((a_lock !== v || b_lock !== v) && n < 400) begin
      @(negedge i_core_clk);
      n++;
    end
    chk("main lock a", 32'(v), 32'(a_lock));
    chk("main lock b", 32'(v), 32'(b_lock));
    @(posedge i_core_clk);
  endtask : wait_lock

  task automatic cmp_clocks;
    chk("a main", 32'(bus_ref), 32'(a_main));
    chk("a inv", 32'(!a_main), 32'(a_inv));
    chk("a dbl", 32'(bus_ref), 32'(a_dbl));
    chk("a mem", 32'(bus_ref), 32'(a_mem));
    chk("a bus pass", 32'(bus_ref), 32'(a_pass));
    chk("b main", 32'(main_ref), 32'(b_main));
    chk("b inv", 32'(!b_main), 32'(b_inv));
    chk("b dbl", 32'h0, 32'(b_dbl));
    chk("b mem", 32'(main_ref), 32'(b_mem));
    chk("b bus pass", 32'h0, 32'(b_pass));
    chk("bus locks", 32'h3, 32'({a_blk, b_blk}));
  endtask : cmp_clocks

  task automatic clk_checks;
    repeat (3) begin
      @(posedge bus_ref);
      #2;
      cmp_clocks();
      @(negedge bus_ref);
      #2;
      cmp_clocks();
    end
    @(posedge i_core_clk);
  endtask : clk_checks

  // Read results land one cycle after the strobe
  always @(posedge i_core_clk) rd_d <= i_rd;
  always @(negedge i_core_clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value read queue expected entry seen none");
      end else begin
        mon_e = exp_q.pop_front();
        chk("read a", mon_e[31:0], rdata_a);
        chk("read b", mon_e[63:32], rdata_b);
      end
    end else begin
      chk("idle read", 32'h0, rdata_a | rdata_b);
    end
  end

  initial begin
    #200_000;
    failures++;
    $display("wrong value watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    logic [7:0] a;
    void'($urandom(32'ha4db));
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    repeat (4) @(posedge i_core_clk);
    chk("bus lock in reset", 32'h3, 32'({a_blk, b_blk}));
    chk("main lock in reset", 32'h0, 32'({a_lock, b_lock}));
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    wait_lock(1'b1);
    rd(pll_wrap_pkg::REG_CTRL, 64'h0);
    rd(pll_wrap_pkg::REG_STATUS, stat(1'b1, 1'b0));
    rd(pll_wrap_pkg::REG_CONFIG, cfg());
    $display("test reset and status done");
    clk_checks();
    $display("test clock wiring done");
    wr(pll_wrap_pkg::REG_CTRL, 32'h1);
    wait_lock(1'b0);
    rd(pll_wrap_pkg::REG_STATUS, stat(1'b0, 1'b1));
    rd(pll_wrap_pkg::REG_CTRL, {32'h1, 32'h1});
    clk_checks();
    wr(pll_wrap_pkg::REG_CTRL, 32'h0);
    @(negedge i_core_clk);
    chk("early lock", 32'h0, 32'({a_lock, b_lock}));
    wait_lock(1'b1);
    rd(pll_wrap_pkg::REG_STATUS, stat(1'b1, 1'b0));
    $display("test hold and relock done");
    repeat (6) begin
      a = 8'h0c + 8'(($urandom % 60) * 4);
      wr(a, $urandom);
      rd(a, 64'h0);
    end
    wr(pll_wrap_pkg::REG_STATUS, $urandom);
    wr(pll_wrap_pkg::REG_CONFIG, $urandom);
    rd(pll_wrap_pkg::REG_STATUS, stat(1'b1, 1'b0));
    rd(pll_wrap_pkg::REG_CONFIG, cfg());
    rd(pll_wrap_pkg::REG_CTRL, 64'h0);
    $display("test refused accesses done");
    repeat (2) @(posedge i_core_clk);
    close_out();
  end
endmodule : test_pll_clock_generator_wrapper
